//--- core/eict_double_table.sv
// double-operand table lookup with operation reductions
`timescale 1ns/1ps
module eict_double_table (
    // request
    input  eict_pkg::eict_req_t req,
    // answer
    output eict_pkg::eict_ans_t ans
);
    import eict_pkg::*;

    logic               dReg;
    logic               dPc;
    logic               srcInd;
    logic               srcMem;
    logic [EICT_CW-1:0] cnt;

    always_comb
    begin
        dReg   = (req.dstMode == EICT_AM_REG);
        dPc    = (req.dstMode == EICT_AM_PC);
        srcInd = (req.srcMode == EICT_AM_INDIR) || (req.srcMode == EICT_AM_AUTOINC);
        srcMem = (req.srcMode == EICT_AM_INDEXED) || (req.srcMode == EICT_AM_SYMBOLIC)
                 || (req.srcMode == EICT_AM_ABSOLUTE);
        cnt    = {{(EICT_CW-EICT_NW){1'b0}}, req.count};
        ans    = EICT_ANS_RST;
        // register, pc and memory destinations; immediate or indirect destinations are illegal
        ans.legal = (req.opClass == EICT_OP_DOUBLE) && (req.srcMode != EICT_AM_PC)
                    && (dReg || dPc || req.dstMode == EICT_AM_INDEXED
                        || req.dstMode == EICT_AM_SYMBOLIC || req.dstMode == EICT_AM_ABSOLUTE);
        if (req.srcMode == EICT_AM_REG)
        begin
            ans.cycles = dReg ? EICT_CY_2 : dPc ? EICT_CY_4
                       : (req.wide ? EICT_CY_7 : EICT_CY_5);
            ans.words  = (dReg || dPc) ? EICT_LEN_2 : EICT_LEN_3;
        end
        else if (srcInd)
        begin
            ans.cycles = dReg ? (req.wide ? EICT_CY_4 : EICT_CY_3)
                       : dPc ? (req.wide ? EICT_CY_6 : EICT_CY_5)
                       : (req.wide ? EICT_CY_9 : EICT_CY_6);
            ans.words  = (dReg || dPc) ? EICT_LEN_2 : EICT_LEN_3;
        end
        else if (req.srcMode == EICT_AM_IMM)
        begin
            ans.cycles = dReg ? EICT_CY_3 : dPc ? EICT_CY_4
                       : (req.wide ? EICT_CY_8 : EICT_CY_6);
            ans.words  = (dReg || dPc) ? EICT_LEN_3 : EICT_LEN_4;
        end
        else
        begin
            ans.cycles = dReg ? (req.wide ? EICT_CY_5 : EICT_CY_4)
                       : dPc ? (req.wide ? EICT_CY_7 : EICT_CY_6)
                       : (req.wide ? EICT_CY_10 : EICT_CY_7);
            ans.words  = (dReg || dPc) ? EICT_LEN_3 : EICT_LEN_4;
        end
        if (!dReg && !dPc && req.flavour == EICT_FL_NOWRITE)
            ans.cycles = ans.cycles - (req.wide ? EICT_CY_2 : EICT_CY_1);
        if (dPc && (srcMem || req.srcMode == EICT_AM_IMM)
            && (req.flavour == EICT_FL_ADDSUB || req.flavour == EICT_FL_NOWRITE))
            ans.cycles = ans.cycles - EICT_CY_1;
        if (req.isRepeat && req.srcMode == EICT_AM_REG && dReg)
            ans.cycles = cnt + EICT_CY_1;
    end

endmodule : eict_double_table

//--- core/eict_pkg.sv
// package: encodings, table figures and the request/answer carriers of the timing model
package eict_pkg;

    // addressing modes
    typedef enum logic [2:0] {
        EICT_AM_REG      = 3'h0,
        EICT_AM_INDIR    = 3'h1,
        EICT_AM_AUTOINC  = 3'h2,
        EICT_AM_IMM      = 3'h3,
        EICT_AM_INDEXED  = 3'h4,
        EICT_AM_SYMBOLIC = 3'h5,
        EICT_AM_ABSOLUTE = 3'h6,
        EICT_AM_PC       = 3'h7
    } eict_mode_t;

    // instruction classes
    typedef enum logic [3:0] {
        EICT_OP_MULTI_SHIFT   = 4'h0,
        EICT_OP_MULTI_PUSHPOP = 4'h1,
        EICT_OP_WIDE_CALL     = 4'h2,
        EICT_OP_EXT_ROTATE    = 4'h3,
        EICT_OP_EXT_PUSH      = 4'h4,
        EICT_OP_EXT_POP       = 4'h5,
        EICT_OP_DOUBLE        = 4'h6
    } eict_class_t;

    // operation flavour for the double-operand reductions
    typedef enum logic [1:0] {
        EICT_FL_OTHER   = 2'h0,
        EICT_FL_NOWRITE = 2'h1,
        EICT_FL_ADDSUB  = 2'h2
    } eict_flavour_t;

    localparam int EICT_CW = 8;
    localparam int EICT_LW = 3;
    localparam int EICT_NW = 5;

    typedef struct packed {
        eict_class_t       opClass;
        eict_mode_t        srcMode;
        eict_mode_t        dstMode;
        logic              wide;
        logic              spBase;
        logic              isRepeat;
        eict_flavour_t     flavour;
        logic [EICT_NW-1:0] count;
    } eict_req_t;

    typedef struct packed {
        logic [EICT_CW-1:0] cycles;
        logic [EICT_LW-1:0] words;
        logic               legal;
    } eict_ans_t;

    // lengths in words
    localparam logic [EICT_LW-1:0] EICT_LEN_1 = 3'h1;
    localparam logic [EICT_LW-1:0] EICT_LEN_2 = 3'h2;
    localparam logic [EICT_LW-1:0] EICT_LEN_3 = 3'h3;
    localparam logic [EICT_LW-1:0] EICT_LEN_4 = 3'h4;

    // fixed cycle figures
    localparam logic [EICT_CW-1:0] EICT_CY_1  = 8'h01;
    localparam logic [EICT_CW-1:0] EICT_CY_2  = 8'h02;
    localparam logic [EICT_CW-1:0] EICT_CY_3  = 8'h03;
    localparam logic [EICT_CW-1:0] EICT_CY_4  = 8'h04;
    localparam logic [EICT_CW-1:0] EICT_CY_5  = 8'h05;
    localparam logic [EICT_CW-1:0] EICT_CY_6  = 8'h06;
    localparam logic [EICT_CW-1:0] EICT_CY_7  = 8'h07;
    localparam logic [EICT_CW-1:0] EICT_CY_8  = 8'h08;
    localparam logic [EICT_CW-1:0] EICT_CY_9  = 8'h09;
    localparam logic [EICT_CW-1:0] EICT_CY_10 = 8'h0A;

    localparam eict_ans_t EICT_ANS_RST = '{cycles: 8'h00, words: 3'h0, legal: 1'b0};

endpackage : eict_pkg

//--- core/eict_single_table.sv
// single-operand table lookup
`timescale 1ns/1ps
module eict_single_table (
    // request
    input  eict_pkg::eict_req_t req,
    // answer
    output eict_pkg::eict_ans_t ans
);
    import eict_pkg::*;

    logic [EICT_CW-1:0] cnt;
    logic               isReg;
    logic               isInd;
    logic               isMem;

    always_comb
    begin
        cnt   = {{(EICT_CW-EICT_NW){1'b0}}, req.count};
        isReg = (req.srcMode == EICT_AM_REG);
        isInd = (req.srcMode == EICT_AM_INDIR) || (req.srcMode == EICT_AM_AUTOINC);
        isMem = (req.srcMode == EICT_AM_INDEXED) || (req.srcMode == EICT_AM_SYMBOLIC)
                || (req.srcMode == EICT_AM_ABSOLUTE);
        ans   = EICT_ANS_RST;
        unique case (req.opClass)
            EICT_OP_MULTI_SHIFT:
            begin
                ans.legal  = isReg;
                ans.cycles = cnt;
                ans.words  = EICT_LEN_1;
            end
            EICT_OP_MULTI_PUSHPOP:
            begin
                ans.legal  = isReg;
                ans.cycles = req.wide ? (EICT_CY_2 + (cnt << 1)) : (EICT_CY_2 + cnt);
                ans.words  = EICT_LEN_1;
            end
            EICT_OP_WIDE_CALL:
            begin
                ans.legal = isReg || isInd || isMem || (req.srcMode == EICT_AM_IMM);
                if (isReg)
                begin
                    ans.cycles = EICT_CY_5;
                    ans.words  = EICT_LEN_1;
                end
                else if (isInd)
                begin
                    ans.cycles = EICT_CY_6;
                    ans.words  = EICT_LEN_1;
                end
                else if (req.srcMode == EICT_AM_INDEXED)
                begin
                    ans.cycles = req.spBase ? EICT_CY_6 : EICT_CY_5;
                    ans.words  = EICT_LEN_2;
                end
                else
                begin
                    ans.cycles = (req.srcMode == EICT_AM_IMM) ? EICT_CY_5 : EICT_CY_7;
                    ans.words  = EICT_LEN_2;
                end
            end
            EICT_OP_EXT_ROTATE:
            begin
                ans.legal = isReg || isInd || isMem;
                if (isReg)
                begin
                    ans.cycles = EICT_CY_1 + cnt;
                    ans.words  = EICT_LEN_2;
                end
                else if (isInd)
                begin
                    ans.cycles = req.wide ? EICT_CY_6 : EICT_CY_4;
                    ans.words  = EICT_LEN_2;
                end
                else
                begin
                    ans.cycles = req.wide ? EICT_CY_7 : EICT_CY_5;
                    ans.words  = EICT_LEN_3;
                end
            end
            EICT_OP_EXT_PUSH:
            begin
                ans.legal = (req.srcMode != EICT_AM_PC);
                if (!req.wide)
                begin
                    // every memory mode pays the extra fetch, not only indexed
                    ans.cycles = isMem ? EICT_CY_5 : EICT_CY_4;
                    ans.words  = (isReg || isInd) ? EICT_LEN_2 : EICT_LEN_3;
                end
                else if (isReg || req.srcMode == EICT_AM_IMM)
                begin
                    ans.cycles = EICT_CY_5;
                    ans.words  = isReg ? EICT_LEN_2 : EICT_LEN_3;
                end
                else
                begin
                    ans.cycles = isInd ? EICT_CY_6 : EICT_CY_7;
                    ans.words  = isInd ? EICT_LEN_2 : EICT_LEN_3;
                end
                if (req.srcMode == EICT_AM_INDEXED && req.spBase)
                    ans.cycles = ans.cycles + EICT_CY_1;
            end
            EICT_OP_EXT_POP:
            begin
                ans.legal = isReg || isMem;
                if (isReg)
                begin
                    ans.cycles = req.wide ? EICT_CY_4 : EICT_CY_3;
                    ans.words  = EICT_LEN_2;
                end
                else
                begin
                    ans.cycles = req.wide ? EICT_CY_7 : EICT_CY_5;
                    ans.words  = EICT_LEN_3;
                end
            end
            default:
            begin
                ans = EICT_ANS_RST;
            end
        endcase
    end

endmodule : eict_single_table

//--- core/eict_timing.sv
// extended instruction cycle and length model, registered answer
`timescale 1ns/1ps
module eict_timing (
    // clock and reset
    input  logic                clk_sys,
    input  logic                srst,
    // request
    input  logic                reqValid,
    input  eict_pkg::eict_req_t req,
    // answer
    output logic                ansValid_ff,
    output eict_pkg::eict_ans_t ans_ff
);
    import eict_pkg::*;

    eict_ans_t singleAns;
    eict_ans_t doubleAns;
    eict_ans_t nxt_ans;
    logic      nxt_ansValid;

    eict_single_table u_single (
        .req (req),
        .ans (singleAns)
    );

    eict_double_table u_double (
        .req (req),
        .ans (doubleAns)
    );

    // answer depends on class, modes, wide, spBase, isRepeat and count; the flavour only trims counts
    always_comb
    begin
        nxt_ansValid = reqValid;
        nxt_ans      = ans_ff;
        if (reqValid)
            nxt_ans = (req.opClass == EICT_OP_DOUBLE) ? doubleAns : singleAns;
    end

    // one-cycle latency keeps the outputs glitch free for the sequencer
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ansValid_ff <= 1'b0;
            ans_ff      <= EICT_ANS_RST;
        end
        else
        begin
            ansValid_ff <= nxt_ansValid;
            ans_ff      <= nxt_ans;
        end
    end

endmodule : eict_timing

//--- tb/eict_timing_asserts.sv
// checker: answer timing of the cycle model and selected table figures
`timescale 1ns/1ps
module eict_timing_asserts (
    // clock and reset
    input logic                clk_sys,
    input logic                srst,
    // request
    input logic                reqValid,
    input eict_pkg::eict_req_t req,
    // answer
    input logic                ansValid_ff,
    input eict_pkg::eict_ans_t ans_ff
);
    import eict_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    ans_follows_a: assert property (reqValid |=> ansValid_ff)
        else $error("no answer one cycle after a request");
    ans_holds_a: assert property (!reqValid |=> !ansValid_ff && $stable(ans_ff))
        else $error("answer moved without a request");
    reset_clear_a: assert property (
        $fell(srst) |-> !ansValid_ff && ans_ff == EICT_ANS_RST)
        else $error("answer not cleared by reset");
    shift_count_a: assert property (
        reqValid && req.opClass == EICT_OP_MULTI_SHIFT && req.srcMode == EICT_AM_REG
        |=> ans_ff.cycles == 8'($past(req.count)) && ans_ff.words == 3'h1)
        else $error("multi shift count wrong");
    shift_mode_a: assert property (
        reqValid && req.opClass == EICT_OP_MULTI_SHIFT && req.srcMode != EICT_AM_REG
        |=> !ans_ff.legal)
        else $error("multi shift accepted a memory mode");
    pushpop_count_a: assert property (
        reqValid && req.opClass == EICT_OP_MULTI_PUSHPOP && req.srcMode == EICT_AM_REG
        |=> ans_ff.cycles == 8'(2 + ($past(req.wide) ? 2 : 1) * $past(req.count)))
        else $error("multi register push pop count wrong");
    rotate_reg_a: assert property (
        reqValid && req.opClass == EICT_OP_EXT_ROTATE && req.srcMode == EICT_AM_REG
        |=> ans_ff.cycles == 8'(1 + $past(req.count)) && ans_ff.words == 3'h2)
        else $error("rotate register count wrong");
    push_mem_a: assert property (
        reqValid && req.opClass == EICT_OP_EXT_PUSH && !req.wide
        && req.srcMode inside {EICT_AM_SYMBOLIC, EICT_AM_ABSOLUTE}
        |=> ans_ff.cycles == 8'h05 && ans_ff.words == 3'h3)
        else $error("byte push from memory count wrong");
    repeat_count_a: assert property (
        reqValid && req.opClass == EICT_OP_DOUBLE && req.isRepeat
        && req.srcMode == EICT_AM_REG && req.dstMode == EICT_AM_REG
        |=> ans_ff.cycles == 8'(1 + $past(req.count)))
        else $error("repeat count wrong");
    call_sp_a: assert property (
        reqValid && req.opClass == EICT_OP_WIDE_CALL && req.srcMode == EICT_AM_INDEXED
        |=> ans_ff.cycles == 8'(5 + $past(req.spBase)))
        else $error("indexed call count wrong");
    pop_mode_a: assert property (
        reqValid && req.opClass == EICT_OP_EXT_POP
        && req.srcMode inside {EICT_AM_INDIR, EICT_AM_AUTOINC, EICT_AM_IMM} |=> !ans_ff.legal)
        else $error("pop accepted an indirect or immediate mode");

    back_to_back_c: cover property (reqValid ##1 reqValid);
    call_sp_c: cover property (reqValid && req.spBase && req.opClass == EICT_OP_WIDE_CALL);
    reset_exit_c: cover property ($fell(srst));
endmodule : eict_timing_asserts

bind eict_timing eict_timing_asserts eict_timing_asserts_inst (
    .clk_sys(clk_sys), .srst(srst), .reqValid(reqValid), .req(req),
    .ansValid_ff(ansValid_ff), .ans_ff(ans_ff));

//--- tb/test_extended_insn_cycle_timing.sv
// bench: swept and random requests against a table model of the answers
`timescale 1ns/1ps
module test_extended_insn_cycle_timing;
    import eict_pkg::*;
    logic      clk_sys;
    logic      srst;
    logic      reqValid;
    eict_req_t req;
    logic      ansValid_ff;
    eict_ans_t ans_ff;
    logic      pv;
    eict_ans_t last;
    int        error_cnt;
    int        n_tests;
    int        seed;

    eict_timing eict_timing_inst (.clk_sys(clk_sys), .srst(srst), .reqValid(reqValid),
        .req(req), .ansValid_ff(ansValid_ff), .ans_ff(ans_ff));

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // 0 register, 1 indirect, 2 immediate, 3 indexed, 4 symbolic/absolute, 5 pc
    function automatic int cat(eict_mode_t m);
        case (m)
            EICT_AM_REG: return 0;
            EICT_AM_INDIR, EICT_AM_AUTOINC: return 1;
            EICT_AM_IMM: return 2;
            EICT_AM_INDEXED: return 3;
            EICT_AM_PC: return 5;
            default: return 4;
        endcase
    endfunction : cat

    function automatic eict_ans_t ref_ans(eict_req_t r);
        int cbw[4][3] = '{'{2, 4, 5}, '{3, 5, 6}, '{3, 4, 6}, '{4, 6, 7}};
        int cwd[4][3] = '{'{2, 4, 7}, '{4, 6, 9}, '{3, 4, 8}, '{5, 7, 10}};
        int tc[5] = '{0, 0, 0, 0, 0};
        int tw[5] = '{1, 1, 1, 1, 1};
        int k = cat(r.srcMode);
        int d = cat(r.dstMode);
        int n = r.count;
        int wd = r.wide;
        int sp = r.spBase;
        int s;
        int dd;
        int c;
        bit ok;
        eict_ans_t a;
        ok = (k < 5);
        case (r.opClass)
            EICT_OP_MULTI_SHIFT: tc[0] = n;
            EICT_OP_MULTI_PUSHPOP: tc[0] = 2 + (wd + 1) * n;
            EICT_OP_WIDE_CALL:
            begin
                tc = '{5, 6, 5, 5 + sp, 7};
                tw = '{1, 1, 2, 2, 2};
            end
            EICT_OP_EXT_ROTATE:
            begin
                tc = '{1 + n, 4 + 2 * wd, 0, 5 + 2 * wd, 5 + 2 * wd};
                tw = '{2, 2, 0, 3, 3};
            end
            EICT_OP_EXT_PUSH:
            begin
                tc = '{4 + wd, 4 + 2 * wd, 4 + wd, 5 + 2 * wd + sp, 5 + 2 * wd};
                tw = '{2, 2, 3, 3, 3};
            end
            EICT_OP_EXT_POP:
            begin
                tc = '{3 + wd, 0, 0, 5 + 2 * wd, 5 + 2 * wd};
                tw = '{2, 0, 0, 3, 3};
            end
            default:
            begin
                s = (k == 4) ? 3 : k;
                dd = (d == 0) ? 0 : (d == 5) ? 1 : (d >= 3) ? 2 : 9;
                ok = ok && dd < 9;
                if (ok)
                begin
                    c = wd ? cwd[s][dd] : cbw[s][dd];
                    if (dd == 2 && r.flavour == EICT_FL_NOWRITE) c -= 1 + wd;
                    if (dd == 1 && s >= 2 && r.flavour != EICT_FL_OTHER) c -= 1;
                    if (r.isRepeat && s == 0 && dd == 0) c = n + 1;
                    tc[k] = c;
                    tw[k] = ((s < 2) ? 2 : 3) + (dd == 2);
                end
            end
        endcase
        if (r.opClass inside {EICT_OP_MULTI_SHIFT, EICT_OP_MULTI_PUSHPOP}) ok = (k == 0);
        if (r.opClass == EICT_OP_EXT_ROTATE) ok = ok && k != 2;
        if (r.opClass == EICT_OP_EXT_POP) ok = ok && (k == 0 || k >= 3);
        a = EICT_ANS_RST;
        if (ok)
        begin
            a.cycles = 8'(tc[k]);
            a.words = 3'(tw[k]);
            a.legal = 1'b1;
        end
        return a;
    endfunction : ref_ans

    // flags, flavour and count are random; the count stays in 1 to 16
    function automatic eict_req_t mk(int c, int s, int d);
        eict_req_t r;
        r.opClass = eict_class_t'(c);
        r.srcMode = eict_mode_t'(s);
        r.dstMode = eict_mode_t'(d);
        {r.wide, r.spBase, r.isRepeat} = 3'($random(seed));
        r.flavour = eict_flavour_t'($unsigned($random(seed)) % 3);
        r.count = 5'(1 + $unsigned($random(seed)) % 16);
        return r;
    endfunction : mk

    // checks the answer to the previous cycle's request, then drives the next one
    task automatic issue(input logic v, input eict_req_t r);
        @(posedge clk_sys);
        #1;
        check(16'(ansValid_ff), 16'(pv));
        check(16'(ans_ff.legal), 16'(last.legal));
        if (last.legal) check(16'({ans_ff.cycles, ans_ff.words}), 16'({last.cycles, last.words}));
        if (v) last = ref_ans(r);
        pv = v;
        reqValid = v;
        req = r;
    endtask : issue

    // requests held up during reset must not answer
    task automatic do_reset(input int n);
        @(posedge clk_sys);
        #1;
        srst = 1'b1;
        reqValid = 1'b1;
        repeat (n) @(posedge clk_sys);
        #1;
        check(16'({ansValid_ff, ans_ff}), 16'h0000);
        srst = 1'b0;
        reqValid = 1'b0;
        pv = 1'b0;
        last = EICT_ANS_RST;
    endtask : do_reset

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    initial
    begin
        seed = 32'h1537;
        error_cnt = 0;
        n_tests = 0;
        srst = 1'b1;
        reqValid = 1'b0;
        req = '0;
        do_reset(10);
        for (int i = 0; i < 1792; i++)
            issue(1'b1, mk(i / 256, i % 8, (i / 8) % 8));
        for (int i = 0; i < 2000; i++)
        begin
            if (i == 1000) do_reset(2);
            issue(($random(seed) & 3) != 0, mk($unsigned($random(seed)) % 7,
                $unsigned($random(seed)) % 8, $unsigned($random(seed)) % 8));
        end
        issue(1'b0, req);
        issue(1'b0, req);
        end_sim();
    end

    // the run needs about 3800 cycles; twice that means a hang
    initial
    begin
        #320000;
        error_cnt++;
        end_sim();
    end
endmodule : test_extended_insn_cycle_timing
